// *** rtl/vbi_pkg.sv ***
/*
 * shared constants, types and state layout for the sliced vbi packet output block.
 * assumes one 20 mhz clock with a synchronous active-high reset, and an apb master.
 */
package vbi_pkg;
	// apb register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_REQUEST = 8'h04;
	localparam logic [7:0] ADDR_DATA = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	// control register field positions
	localparam int CTRL_TAG_LSB = 0;
	localparam int CTRL_OE_BIT = 8;
	localparam int CTRL_SEL0_LSB = 16;
	localparam int CTRL_SEL1_LSB = 20;
	// request register field positions
	localparam int REQ_LINE_LSB = 0;
	localparam int REQ_FIELD_BIT = 9;
	localparam int REQ_TYPE_LSB = 10;
	localparam int REQ_COUNT_LSB = 16;
	// status register field positions
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_FILL_LSB = 1;
	localparam int STAT_ADDR_LSB = 8;
	localparam int STAT_WC_LSB = 16;
	// packet framing
	localparam logic [7:0] BLANK_FIRST = 8'h80;
	localparam logic [7:0] BLANK_SECOND = 8'h10;
	localparam logic [7:0] TIMING_FF = 8'hff;
	localparam logic [7:0] TIMING_00 = 8'h00;
	localparam int MAX_DATA = 42;
	localparam logic [3:0] WC_MIN = 4'h1;
	localparam logic [3:0] WC_MAX = 4'hb;
	localparam logic [3:0] ID_BYTES = 4'h2;
	// slave address pairs, write address kept; read address is write plus one
	localparam logic [7:0] ADDR_DEFAULT = 8'h4a;
	localparam logic [7:0] ADDR_STRAPPED = 8'h48;
	localparam logic [3:0] SEL_INPUT = 4'h0;
	localparam logic [3:0] SEL_ACTIVE = 4'h1;
	localparam logic [3:0] SEL_FIELD = 4'h2;
	localparam logic [3:0] SEL_SERIAL = 4'h3;
	// realtime status frame: start bit, line clock step, subcarrier step, reset, sequence
	localparam int LINE_INC_W = 22;
	localparam int SC_INC_W = 24;
	localparam int RT_FRAME_W = 1 + LINE_INC_W + SC_INC_W + 2;
	localparam logic [5:0] RT_LAST = 6'(RT_FRAME_W - 1);
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	typedef enum logic [3:0] {
		PH_BLANK_A = 4'b0000,
		PH_BLANK_B = 4'b0001,
		PH_PRE = 4'b0010,
		PH_TAG = 4'b0011,
		PH_COUNT = 4'b0100,
		PH_ID1 = 4'b0101,
		PH_ID2 = 4'b0110,
		PH_DATA = 4'b0111,
		PH_POST = 4'b1000
	} phase_t;

	typedef struct packed {
		logic [LINE_INC_W-1:0] line_inc;
		logic [SC_INC_W-1:0] sc_inc;
		logic phase_reset;
		logic pal_bit;
	} rt_status_t;

	typedef struct packed {
		logic [7:0] sav;
		logic [7:0] eav;
	} timing_code_t;

	typedef struct packed {
		logic in;
		logic out;
		logic oe;
	} pin_t;

	typedef struct packed {
		phase_t phase;
		logic [6:0] idx;
		logic [7:0] port_byte;
		logic busy;
		logic [5:0] fill;
		logic [MAX_DATA-1:0][7:0] data_buf;
		logic [5:0] tag;
		logic out_en;
		logic [3:0] sel0;
		logic [3:0] sel1;
		logic [8:0] line;
		logic field;
		logic [3:0] dtype;
		logic [5:0] nbytes;
		logic [3:0] wc;
		logic [31:0] prdata;
		logic pslverr;
		logic strap_done;
		logic [7:0] slave_addr;
		logic [RT_FRAME_W-1:0] rt_shift;
		logic [5:0] rt_cnt;
		logic pin0_out;
		logic pin1_out;
	} state_t;
endpackage

// *** rtl/vbi_sliced_packet_output.sv ***
/*
 * sliced vbi packet framer for the 8-bit video output port, with apb registers,
 * realtime status serial output, two multifunction pins and the address strap.
 * assumes the apb master, the timing code source and the realtime status inputs
 * are synchronous to sys_clk; the port clock is sys_clk, one byte per edge.
 */
// Summary of operation
// - source tag byte follows start code; low six bits from software field.
// - tag, count and nibble bytes: bit 6 makes bits 6..0 even.
// - tag, count and nibble bytes: bit 7 is inverse of bit 6.
// - both line id bytes carry odd parity over all eight bits.
// - count byte holds (2 + decoded bytes) / 4 words.
// - a fractional word count rounds up.
// - word count stays between 1 and 11.
// - bytes from first id byte never exceed eight times count minus two.
// - first id byte: field flag bit 6, line bits 8..3 in 5..0.
// - second id byte: line bits 2..0 in 6..4, type in 3..0.
// - low nibble byte: data 3..0 in bits 5..2, bits 1..0 ones.
// - high nibble byte: data 7..4 in bits 5..2, bits 1..0 ones.
// - order: blanking, ff 00 00 sav, tag, count, ids, nibbles, ff 00 00 eav.
// - realtime serial output carries line clock, subcarrier, phase reset, sequence bit.
// - each multifunction pin takes its function from its own select field.
// - strap on pin zero sampled at the first edge after reset release picks the alternate address pair.
// - pin one select of zero makes pin one the port tristate input.
// - port drives only with output enable set and tristate input low.
module vbi_sliced_packet_output
	import vbi_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire timing_code_t timing,
	input wire rt_status_t rt_status,
	output logic realtime_status_serial,
	output logic [7:0] video_port_out,
	output logic video_port_oe,
	input wire logic multipin_zero_in,
	output logic multipin_zero_out,
	output logic multipin_zero_oe,
	input wire logic multipin_one_in,
	output logic multipin_one_out,
	output logic multipin_one_oe,
	output logic [7:0] slave_addr_write,
	output logic [7:0] slave_addr_read
);
	state_t st;
	state_t next_st;
	logic wr_en;
	logic tristate_mode;

	// parity pair in bits 7 and 6 above six payload bits
	function automatic logic [7:0] even_pair(input logic [5:0] v);
		logic even_parity_bit;
		even_parity_bit = ^v;
		return {~even_parity_bit, even_parity_bit, v};
	endfunction

	// odd parity bit in bit 7 above seven payload bits
	function automatic logic [7:0] odd_byte(input logic [6:0] v);
		logic odd_parity_bit;
		odd_parity_bit = ~^v;
		return {odd_parity_bit, v};
	endfunction

	// byte shown on the port while in a given phase
	function automatic logic [7:0] byte_for(input state_t s, input timing_code_t t);
		logic [7:0] b;
		logic [7:0] d;
		b = BLANK_FIRST;
		d = s.data_buf[s.idx[6:1]];
		case (s.phase)
			PH_BLANK_A: b = BLANK_FIRST;
			PH_BLANK_B: b = BLANK_SECOND;
			PH_PRE, PH_POST: begin
				case (s.idx[1:0])
					2'h0: b = TIMING_FF;
					2'h1, 2'h2: b = TIMING_00;
					default: b = (s.phase == PH_PRE) ? t.sav : t.eav;
				endcase
			end
			PH_TAG: b = even_pair(s.tag);
			PH_COUNT: b = even_pair({2'b00, s.wc});
			PH_ID1: b = odd_byte({s.field, s.line[8:3]});
			PH_ID2: b = odd_byte({s.line[2:0], s.dtype});
			PH_DATA: begin
				if (s.idx[0] == 1'b0) begin
					b = even_pair({d[3:0], 2'b11});
				end else begin
					b = even_pair({d[7:4], 2'b11});
				end
			end
			default: b = BLANK_FIRST;
		endcase
		return b;
	endfunction

	// word count from the decoded byte total, rounded up and kept in range
	function automatic logic [3:0] words_for(input logic [5:0] n);
		logic [6:0] total;
		logic [3:0] w;
		total = 7'(n) + 7'(ID_BYTES) + 7'h3;
		w = total[5:2];
		if (w < WC_MIN) begin
			w = WC_MIN;
		end else if (w > WC_MAX) begin
			w = WC_MAX;
		end
		return w;
	endfunction

	assign wr_en = psel && penable && pwrite;
	assign tristate_mode = (st.sel1 == SEL_INPUT);

	// next state of bus slave, framer, strap and serial shifter
	always_comb begin
		next_st = st;
		// apb read data captured in the setup cycle
		if (psel && !penable) begin
			next_st.pslverr = 1'b0;
			next_st.prdata = 32'h0000_0000;
			case (paddr)
				ADDR_CTRL: begin
					next_st.prdata[CTRL_TAG_LSB +: 6] = st.tag;
					next_st.prdata[CTRL_OE_BIT] = st.out_en;
					next_st.prdata[CTRL_SEL0_LSB +: 4] = st.sel0;
					next_st.prdata[CTRL_SEL1_LSB +: 4] = st.sel1;
				end
				ADDR_REQUEST: begin
					next_st.prdata[REQ_LINE_LSB +: 9] = st.line;
					next_st.prdata[REQ_FIELD_BIT] = st.field;
					next_st.prdata[REQ_TYPE_LSB +: 4] = st.dtype;
					next_st.prdata[REQ_COUNT_LSB +: 6] = st.nbytes;
				end
				ADDR_DATA: next_st.prdata = 32'h0000_0000;
				ADDR_STATUS: begin
					next_st.prdata[STAT_BUSY_BIT] = st.busy;
					next_st.prdata[STAT_FILL_LSB +: 6] = st.fill;
					next_st.prdata[STAT_ADDR_LSB +: 8] = st.slave_addr;
					next_st.prdata[STAT_WC_LSB +: 4] = st.wc;
				end
				default: next_st.pslverr = 1'b1;
			endcase
		end
		// apb writes take effect at the access edge
		if (wr_en) begin
			case (paddr)
				ADDR_CTRL: begin
					next_st.tag = pwdata[CTRL_TAG_LSB +: 6];
					next_st.out_en = pwdata[CTRL_OE_BIT];
					next_st.sel0 = pwdata[CTRL_SEL0_LSB +: 4];
					next_st.sel1 = pwdata[CTRL_SEL1_LSB +: 4];
				end
				ADDR_REQUEST: begin
					if (!st.busy) begin
						next_st.busy = 1'b1;
						next_st.line = pwdata[REQ_LINE_LSB +: 9];
						next_st.field = pwdata[REQ_FIELD_BIT];
						next_st.dtype = pwdata[REQ_TYPE_LSB +: 4];
						next_st.nbytes = pwdata[REQ_COUNT_LSB +: 6];
						// the receiver copes with short packets, so clamp to the buffer
						if (pwdata[REQ_COUNT_LSB +: 6] > 6'(MAX_DATA)) begin
							next_st.nbytes = 6'(MAX_DATA);
						end
						next_st.wc = words_for(next_st.nbytes);
					end
				end
				ADDR_DATA: begin
					if (!st.busy && st.fill < 6'(MAX_DATA)) begin
						next_st.data_buf[st.fill] = pwdata[7:0];
						next_st.fill = st.fill + 6'h1;
					end
				end
				default: next_st.pslverr = st.pslverr;
			endcase
		end
		// packet sequencer, one byte per edge with no gaps
		case (st.phase)
			PH_BLANK_A: next_st.phase = PH_BLANK_B;
			PH_BLANK_B: begin
				if (st.busy) begin
					next_st.phase = PH_PRE;
					next_st.idx = 7'h0;
				end else begin
					next_st.phase = PH_BLANK_A;
				end
			end
			PH_PRE: begin
				next_st.idx = st.idx + 7'h1;
				if (st.idx == 7'h3) begin
					next_st.phase = PH_TAG;
					next_st.idx = 7'h0;
				end
			end
			PH_TAG: next_st.phase = PH_COUNT;
			PH_COUNT: next_st.phase = PH_ID1;
			PH_ID1: next_st.phase = PH_ID2;
			PH_ID2: begin
				next_st.idx = 7'h0;
				next_st.phase = (st.nbytes == 6'h0) ? PH_POST : PH_DATA;
			end
			PH_DATA: begin
				next_st.idx = st.idx + 7'h1;
				// the last high nibble belongs to byte nbytes-1
				if (st.idx == {st.nbytes - 6'h1, 1'b1}) begin
					next_st.phase = PH_POST;
					next_st.idx = 7'h0;
				end
			end
			PH_POST: begin
				next_st.idx = st.idx + 7'h1;
				if (st.idx == 7'h3) begin
					next_st.phase = PH_BLANK_A;
					next_st.idx = 7'h0;
					next_st.busy = 1'b0;
					next_st.fill = 6'h0;
				end
			end
			default: begin
				next_st.phase = PH_BLANK_A;
				next_st.idx = 7'h0;
			end
		endcase
		next_st.port_byte = byte_for(next_st, timing);
		// strap caught once, at the first edge after reset release, pin not driven
		if (!st.strap_done) begin
			next_st.strap_done = 1'b1;
			next_st.slave_addr = multipin_zero_in ? ADDR_DEFAULT : ADDR_STRAPPED;
		end
		// realtime status frame shifted out msb first, reloaded at its end
		if (st.rt_cnt == RT_LAST) begin
			next_st.rt_cnt = 6'h0;
			next_st.rt_shift = {1'b0, rt_status};
		end else begin
			next_st.rt_cnt = st.rt_cnt + 6'h1;
			next_st.rt_shift = {st.rt_shift[RT_FRAME_W-2:0], 1'b1};
		end
		// multifunction pin output levels by select
		case (st.sel0)
			SEL_ACTIVE: next_st.pin0_out = (st.phase != PH_BLANK_A && st.phase != PH_BLANK_B);
			SEL_FIELD: next_st.pin0_out = st.field;
			SEL_SERIAL: next_st.pin0_out = st.rt_shift[RT_FRAME_W-1];
			default: next_st.pin0_out = 1'b0;
		endcase
		case (st.sel1)
			SEL_ACTIVE: next_st.pin1_out = (st.phase != PH_BLANK_A && st.phase != PH_BLANK_B);
			SEL_FIELD: next_st.pin1_out = st.field;
			SEL_SERIAL: next_st.pin1_out = st.rt_shift[RT_FRAME_W-1];
			default: next_st.pin1_out = 1'b0;
		endcase
	end

	// state register with synchronous reset to constants
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st <= '0;
			st.phase <= PH_BLANK_A;
			st.port_byte <= BLANK_FIRST;
			st.slave_addr <= ADDR_DEFAULT;
			st.sel0 <= CTRL_RESET[CTRL_SEL0_LSB +: 4];
			st.sel1 <= CTRL_RESET[CTRL_SEL1_LSB +: 4];
			st.rt_shift <= '1;
		end else begin
			st <= next_st;
		end
	end

	// outputs
	assign prdata = st.prdata;
	assign pready = 1'b1;
	assign pslverr = st.pslverr && psel && penable;
	assign video_port_out = st.port_byte;
	assign video_port_oe = st.out_en && !(tristate_mode && multipin_one_in);
	assign realtime_status_serial = st.rt_shift[RT_FRAME_W-1];
	assign multipin_zero_out = st.pin0_out;
	assign multipin_zero_oe = st.strap_done && (st.sel0 != SEL_INPUT);
	assign multipin_one_out = st.pin1_out;
	assign multipin_one_oe = !tristate_mode;
	assign slave_addr_write = st.slave_addr;
	assign slave_addr_read = st.slave_addr | 8'h01;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);

	sequence s_header;
		st.phase == PH_TAG ##1 st.phase == PH_COUNT ##1 st.phase == PH_ID1 ##1 st.phase == PH_ID2;
	endsequence

	sequence s_timing_lead;
		video_port_out == TIMING_FF ##1 video_port_out == TIMING_00 ##1 video_port_out == TIMING_00;
	endsequence

	a_tag_byte: assert property (st.phase == PH_TAG |-> video_port_out[5:0] == st.tag
		&& ^video_port_out[6:0] == 1'b0 && video_port_out[7] != video_port_out[6])
		else $error("source tag byte wrong");
	a_count_parity: assert property (st.phase == PH_COUNT |-> ^video_port_out[6:0] == 1'b0
		&& video_port_out[7] == !video_port_out[6])
		else $error("count byte parity wrong");
	a_count_range: assert property (st.phase == PH_COUNT |-> video_port_out[5:0] >= 6'h1
		&& video_port_out[5:0] <= 6'hb && video_port_out[5:0] == 6'((st.nbytes + 6'h5) >> 2))
		else $error("word count out of range");
	a_id_odd: assert property ((st.phase == PH_ID1 || st.phase == PH_ID2) |-> ^video_port_out)
		else $error("id byte parity not odd");
	a_id_fields: assert property (st.phase == PH_ID1 |-> video_port_out[6:0] == {st.field,
		st.line[8:3]} ##1 video_port_out[6:0] == {st.line[2:0], st.dtype})
		else $error("id byte fields wrong");
	a_nibble_form: assert property (st.phase == PH_DATA |-> video_port_out[1:0] == 2'b11
		&& ^video_port_out[6:0] == 1'b0 && video_port_out[7] != video_port_out[6])
		else $error("nibble byte form wrong");
	a_max_bytes: assert property (st.phase == PH_DATA |-> 8'(st.idx) + 8'h5 <= 8'(st.wc) * 8'h8)
		else $error("too many bytes for word count");
	a_packet_order: assert property ($rose(st.phase == PH_PRE) |-> s_timing_lead ##2 s_header)
		else $error("packet order broken");
	a_tristate_pin: assert property (tristate_mode && multipin_one_in |-> !video_port_oe
		&& !multipin_one_oe)
		else $error("port driven while tristated");
	a_strap_addr: assert property ($rose(st.strap_done) |-> slave_addr_write ==
		($past(multipin_zero_in) ? ADDR_DEFAULT : ADDR_STRAPPED))
		else $error("strap address wrong");
endmodule

// *** test/video_backend_model.sv ***
/*
 * behavioural back-end receiver for the 8-bit video output port.
 * assumes the port byte is sampled on the rising sys_clk edge while the drive enable is high.
 */
module video_backend_model
	import vbi_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [7:0] video_port_out,
	input wire logic video_port_oe,
	input wire logic [7:0] sav_code
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [23:0] hist;
	logic grab;
	logic [7:0] pkt[$];
	int done_cnt;

	// gathers the bytes between sav and the closing ff; a short packet is taken as complete
	always @(posedge sys_clk) begin
		if (srst) begin
			hist <= 24'h000000;
			grab <= 1'b0;
			done_cnt <= 0;
		end else if (video_port_oe === 1'b1) begin
			hist <= {hist[15:0], video_port_out};
			if (grab && video_port_out == TIMING_FF) begin
				grab <= 1'b0;
				done_cnt <= done_cnt + 1;
			end else if (grab) begin
				pkt.push_back(video_port_out);
			end
			if (hist == 24'hff0000 && video_port_out == sav_code) begin
				grab <= 1'b1;
				pkt.delete();
			end
		end
	end
endmodule

// *** test/vbi_sliced_packet_output_tb.sv ***
/*
 * self-checking bench: apb register tasks, packet framing, tristate control and strap.
 * assumes the back-end model watching the port; apb waits follow pready.
 */
module vbi_sliced_packet_output_tb;
	import vbi_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, srst, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic err;
	timing_code_t timing;
	rt_status_t rt_status;
	logic [7:0] video_port_out, slave_addr_write, slave_addr_read;
	logic video_port_oe, rt_serial, pin0_in, pin0_out, pin0_oe, pin1_in, pin1_out, pin1_oe;
	int mismatches, comparisons, cycles;
	logic [7:0] exp[$];

	vbi_sliced_packet_output dut (.sys_clk(sys_clk), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .timing(timing), .rt_status(rt_status),
		.realtime_status_serial(rt_serial), .video_port_out(video_port_out),
		.video_port_oe(video_port_oe), .multipin_zero_in(pin0_in), .multipin_zero_out(pin0_out),
		.multipin_zero_oe(pin0_oe), .multipin_one_in(pin1_in), .multipin_one_out(pin1_out),
		.multipin_one_oe(pin1_oe), .slave_addr_write(slave_addr_write),
		.slave_addr_read(slave_addr_read));

	video_backend_model model (.sys_clk(sys_clk), .srst(srst), .video_port_out(video_port_out),
		.video_port_oe(video_port_oe), .sav_code(timing.sav));

	// free-running 20 mhz clock
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		comparisons++;
		if (seen !== want) begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h expected=%h", $time, seen, want);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// one apb transfer: setup, access held until pready, then one idle edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic do_reset(input logic strap);
		pin0_in <= strap;
		srst <= 1'b1;
		repeat (5) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		// the strap lands at the first edge after release; let it settle before looking
		@(posedge sys_clk);
	endtask

	function automatic logic [7:0] par6(input logic [5:0] p);
		return {~(^p), ^p, p};
	endfunction

	function automatic logic [7:0] odd7(input logic [6:0] v);
		return {~(^v), v};
	endfunction

	// hunts the start bit of the status frame and compares the 48 bits behind it
	task automatic check_rt();
		logic [47:0] got;
		while (rt_serial !== 1'b0) begin
			@(posedge sys_clk);
		end
		for (int i = 47; i >= 0; i--) begin
			@(posedge sys_clk);
			got[i] = rt_serial;
		end
		check({8'h00, got[47:24]}, {8'h00, rt_status[47:24]});
		check({8'h00, got[23:0]}, {8'h00, rt_status[23:0]});
	endtask

	// loads n bytes, requests a packet and compares the captured bytes
	task automatic send_packet(input int n);
		logic [8:0] line;
		logic [3:0] dtype, wc;
		logic [7:0] d;
		int start;
		line = 9'(n * 11 + 3);
		dtype = 4'(n);
		wc = 4'((n + 5) / 4);
		exp.delete();
		exp.push_back(par6(6'h2a));
		exp.push_back(par6({2'b00, wc}));
		exp.push_back(odd7({n[0], line[8:3]}));
		exp.push_back(odd7({line[2:0], dtype}));
		for (int i = 0; i < n; i++) begin
			d = 8'(8'h5a + i * 37);
			apb(1'b1, ADDR_DATA, {24'h000000, d});
			exp.push_back(par6({d[3:0], 2'b11}));
			exp.push_back(par6({d[7:4], 2'b11}));
		end
		start = model.done_cnt;
		apb(1'b1, ADDR_REQUEST, {10'h000, 6'(n), 2'b00, dtype, n[0], line});
		while (model.done_cnt == start) begin
			@(posedge sys_clk);
		end
		check(32'(model.pkt.size()), 32'(exp.size()));
		check(32'(model.pkt.size() <= 8 * wc), 32'h1);
		for (int i = 0; i < exp.size() && i < model.pkt.size(); i++) begin
			check({24'h0, model.pkt[i]}, {24'h0, exp[i]});
		end
		// busy drops only after the closing timing code, so poll before the next load
		do begin
			apb(1'b0, ADDR_STATUS, 32'h0);
		end while (rd[STAT_BUSY_BIT] !== 1'b0);
		check({28'h0, rd[STAT_WC_LSB +: 4]}, {28'h0, wc});
		check({26'h0, rd[STAT_FILL_LSB +: 6]}, 32'h0);
	endtask

	// cuts a hang short
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 30000) begin
			mismatches++;
			print_verdict();
		end
	end

	initial begin
		mismatches = 0;
		comparisons = 0;
		cycles = 0;
		srst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		timing = '{sav: 8'hab, eav: 8'hb6};
		rt_status = '{line_inc: 22'h2a5c3, sc_inc: 24'h5a1e7c, phase_reset: 1'b1, pal_bit: 1'b0};
		pin0_in = 1'b1;
		pin1_in = 1'b0;
		do_reset(1'b1);
		check_rt();
		apb(1'b0, ADDR_STATUS, 32'h0);
		check({24'h0, rd[15:8]}, 32'h4a);
		check({24'h0, slave_addr_read}, 32'h4b);
		apb(1'b0, 8'h20, 32'h0);
		check({31'h0, err}, 32'h1);
		check(rd, 32'h0);
		// tristate truth table with pin one as port control input
		for (int i = 0; i < 4; i++) begin
			pin1_in <= i[1];
			apb(1'b1, ADDR_CTRL, {8'h00, 4'h0, 4'h1, 7'h00, i[0], 8'h2a});
			check({31'h0, video_port_oe}, {31'h0, i[0] & ~i[1]});
			check({31'h0, pin1_oe}, 32'h0);
			check({31'h0, pin0_oe}, 32'h1);
		end
		apb(1'b1, ADDR_CTRL, {8'h00, 4'h1, 4'h0, 7'h00, 1'b1, 8'h2a});
		check({31'h0, video_port_oe}, 32'h1);
		check({31'h0, pin0_oe}, 32'h0);
		pin1_in <= 1'b0;
		apb(1'b1, ADDR_CTRL, {8'h00, 4'h0, 4'h1, 7'h00, 1'b1, 8'h2a});
		foreach (exp[i]) exp[i] = 8'h00;
		send_packet(0);
		send_packet(1);
		// both pins as field flag copies; the last packet carried field flag one
		apb(1'b1, ADDR_CTRL, {8'h00, 4'h2, 4'h2, 7'h00, 1'b1, 8'h2a});
		@(posedge sys_clk);
		check({31'h0, pin0_out}, 32'h1);
		check({31'h0, pin1_out}, 32'h1);
		check({31'h0, pin1_oe}, 32'h1);
		apb(1'b1, ADDR_CTRL, {8'h00, 4'h0, 4'h1, 7'h00, 1'b1, 8'h2a});
		send_packet(2);
		send_packet(3);
		send_packet(6);
		send_packet(42);
		do_reset(1'b0);
		check({24'h0, slave_addr_write}, 32'h48);
		check({24'h0, slave_addr_read}, 32'h49);
		print_verdict();
	end
endmodule
